// ===== hw/pidl_pkg.sv
// Purpose: shared constants and carriers for the interrupt/diagnostic/loopback bank
// Assumes: 5-bit management register address space, 16-bit register data
// Notes:   event flag bit order matches the event struct field order
package pidl_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned EVT_N  = 8;

    // register offsets within the management space
    localparam logic [ADDR_W-1:0] ADDR_INT  = 5'h11;
    localparam logic [ADDR_W-1:0] ADDR_DIAG = 5'h12;
    localparam logic [ADDR_W-1:0] ADDR_PWR  = 5'h13;

    // field positions
    localparam int unsigned INT_EN_LSB     = 8;
    localparam int unsigned DIAG_NEGOTIATED_FULL_DUPLEX_BIT  = 11;
    localparam int unsigned DIAG_SPEED_BIT = 10;
    localparam int unsigned DIAG_PASS_BIT  = 9;
    localparam int unsigned DIAG_LOCK_BIT  = 8;
    localparam int unsigned PWR_FIELD_W    = 15;
    localparam int unsigned LINK_LOSS_BIT  = 2;

    // reset values
    localparam logic [EVT_N-1:0]       INT_EN_RST = 8'h00;
    localparam logic [EVT_N-1:0]       FLAGS_RST  = 8'h00;
    localparam logic [PWR_FIELD_W-1:0] PWR_RST    = 15'h0020;

    // events that fire on a falling level instead of a rising one
    localparam logic [EVT_N-1:0] FALL_MASK = 8'h04;

    typedef struct packed {
        logic jabber;
        logic receive_error;
        logic page_arrival;
        logic parallel_fault;
        logic partner_ack;
        logic link_good;
        logic remote_fault;
        logic negotiation_done;
    } pidl_event_t;

    typedef struct packed {
        logic full_duplex;
        logic speed_100;
        logic mode_100x;
        logic signal_valid;
        logic manchester_seen;
        logic pll_lock;
    } pidl_status_t;

    typedef struct packed {
        logic [7:0] reserved_bits;
        logic       transformer_ratio_select;
        logic       low_power;
        logic       test_loopback;
        logic       digital_loopback;
        logic       link_pulse_loopback;
        logic       nlp_integrity_test;
        logic       reduce_timer;
    } pidl_pwr_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } pidl_bus_req_t;

    typedef struct packed {
        logic [EVT_N-1:0]  ev_s1;
        logic [EVT_N-1:0]  ev_s2;
        logic [EVT_N-1:0]  ev_d;
        pidl_status_t      st_s1;
        pidl_status_t      st_s2;
        logic              strap_s1;
        logic              strap_s2;
        logic              lock_d;
        logic [EVT_N-1:0]  enable;
        logic [EVT_N-1:0]  flags;
        logic              lock_sticky;
        pidl_pwr_t         pwr;
        logic [DATA_W-1:0] rdata;
        logic              interrupt_output_pin_pin;
        logic              rst_d;
    } pidl_state_t;

endpackage

// ===== hw/pidl_regs.sv
// Purpose: interrupt, diagnostic and power/loopback management registers
// Assumes: event, status and strap inputs arrive from other clock domains or pins
// Notes:   reads return data one cycle later; unmapped addresses read zero
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - interrupt register bits 15:8 are per-event enables, cleared at reset
// - bit 7 sets on jabber, clears when the register is read
// - bit 6 sets on rising receive error, clears on read
// - bit 5 sets when a new partner page arrives, clears on read
// - bit 4 sets on parallel detection fault, clears on read
// - bit 3 sets on received acknowledge in link pulse burst, clears on read
// - bit 2 sets when link drops from good, clears on read
// - bit 1 sets on remote fault, clears on read
// - bit 0 sets when negotiation completes, clears on read
// - diagnostic bit 11 shows negotiated full duplex, read only
// - diagnostic bit 10 shows negotiated 100 Mbps speed, read only
// - in 100BASE-X diagnostic bit 9 shows valid receive signal
// - in 10BASE-T diagnostic bit 9 shows Manchester data detected
// - diagnostic bit 8 sets on PLL lock, stays until read
// - power bit 6 selects transformer ratio, default from strap at reset
// - power bit 5 enables low power mode, resets to one
// - power bit 4 enables test loopback through clock recovery
// - power bit 3 enables digital loopback, resets to zero
// - power bit 2 enables link pulse loopback
// - power bit 1 sends normal pulses instead of bursts in test mode
// - power bit 0 shortens negotiation timers for test
// - interrupt pin active high when polarity bit one, else active low
module pidl_regs (
    input  wire logic                   clk_sys,
    input  wire logic                   srst,
    input  wire pidl_pkg::pidl_bus_req_t bus_req,
    output logic [pidl_pkg::DATA_W-1:0] bus_rdata,
    input  wire pidl_pkg::pidl_event_t  phy_event,
    input  wire pidl_pkg::pidl_status_t phy_status,
    input  wire logic                   ratio_strap,
    input  wire logic                   interrupt_polarity_select,
    output pidl_pkg::pidl_pwr_t         pwr_ctrl,
    output logic                        interrupt_output_pin
);
    import pidl_pkg::*;

    pidl_state_t             st_r;
    pidl_state_t             st_nxt;
    logic [EVT_N-1:0]        set_evt;
    logic                    lock_rise;
    logic                    rd_int;
    logic                    rd_diag;
    logic                    irq_now;
    logic [DATA_W-1:0]       diag_word;

    always_comb begin
        st_nxt = st_r;

        // two-stage synchronisers; first stage only feeds the second
        st_nxt.ev_s1    = phy_event;
        st_nxt.ev_s2    = st_r.ev_s1;
        st_nxt.ev_d     = st_r.ev_s2;
        st_nxt.st_s1    = phy_status;
        st_nxt.st_s2    = st_r.st_s1;
        st_nxt.strap_s1 = ratio_strap;
        st_nxt.strap_s2 = st_r.strap_s1;
        st_nxt.lock_d   = st_r.st_s2.pll_lock;
        st_nxt.rst_d    = srst;

        // edge of each event; link loss watches the falling edge of link good
        set_evt   = (st_r.ev_s2 ^ st_r.ev_d) & (st_r.ev_s2 ^ FALL_MASK);
        lock_rise = st_r.st_s2.pll_lock & ~st_r.lock_d;

        rd_int  = bus_req.rd && (bus_req.addr == ADDR_INT);
        rd_diag = bus_req.rd && (bus_req.addr == ADDR_DIAG);

        diag_word = '0;
        diag_word[DIAG_NEGOTIATED_FULL_DUPLEX_BIT]  = st_r.st_s2.full_duplex;
        diag_word[DIAG_SPEED_BIT] = st_r.st_s2.speed_100;
        diag_word[DIAG_PASS_BIT]  = st_r.st_s2.mode_100x ? st_r.st_s2.signal_valid
                                                         : st_r.st_s2.manchester_seen;
        diag_word[DIAG_LOCK_BIT]  = st_r.lock_sticky;

        // read data captured before the clear so the event is seen once
        st_nxt.rdata = '0;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                ADDR_INT:  st_nxt.rdata = {st_r.enable, st_r.flags};
                ADDR_DIAG: st_nxt.rdata = diag_word;
                ADDR_PWR:  st_nxt.rdata = {1'b0, st_r.pwr};
                default:   st_nxt.rdata = '0;
            endcase
        end

        // a short reset may end before the strap clears its synchroniser,
        // so the ratio default is taken once more on the first free cycle
        if (st_r.rst_d) begin
            st_nxt.pwr.transformer_ratio_select = st_r.strap_s2;
        end

        // writes: only enables and power bits are writable
        if (bus_req.wr && bus_req.addr == ADDR_INT) begin
            st_nxt.enable = bus_req.wdata[INT_EN_LSB +: EVT_N];
        end
        if (bus_req.wr && bus_req.addr == ADDR_PWR) begin
            st_nxt.pwr = bus_req.wdata[PWR_FIELD_W-1:0];
        end

        // read clears, but a simultaneous event survives the clear
        st_nxt.flags = (rd_int ? '0 : st_r.flags) | set_evt;
        st_nxt.lock_sticky = (rd_diag ? 1'b0 : st_r.lock_sticky) | lock_rise;

        // strap is caught through its synchroniser while reset is held
        if (srst) begin
            st_nxt.enable      = INT_EN_RST;
            st_nxt.flags       = FLAGS_RST;
            st_nxt.lock_sticky = 1'b0;
            st_nxt.pwr         = PWR_RST;
            st_nxt.pwr.transformer_ratio_select = st_r.strap_s2;
            st_nxt.rdata       = '0;
            st_nxt.ev_d        = '0;
            st_nxt.lock_d      = 1'b0;
        end

        irq_now = |(st_nxt.enable & st_nxt.flags);
        // pin level computed from next state so it tracks flags without lag
        st_nxt.interrupt_output_pin_pin = interrupt_polarity_select ? irq_now : ~irq_now;
    end

    always_ff @(posedge clk_sys) begin
        st_r <= st_nxt;
    end

    assign bus_rdata            = st_r.rdata;
    assign pwr_ctrl             = st_r.pwr;
    assign interrupt_output_pin = st_r.interrupt_output_pin_pin;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    logic [EVT_N-1:0] chk_set;
    logic             chk_irq;
    assign chk_set = (st_r.ev_s2 ^ st_r.ev_d) & (st_r.ev_s2 ^ FALL_MASK);
    assign chk_irq = |(st_r.enable & st_r.flags);

    sequence s_read_int;
        bus_req.rd && bus_req.addr == ADDR_INT;
    endsequence

    sequence s_read_diag;
        bus_req.rd && bus_req.addr == ADDR_DIAG;
    endsequence

    sequence s_link_drop;
        st_r.ev_d[LINK_LOSS_BIT] ##0 !st_r.ev_s2[LINK_LOSS_BIT];
    endsequence

    chk_enable_reset: assert property (
        disable iff (1'b0) srst |=> st_r.enable == INT_EN_RST && st_r.flags == FLAGS_RST)
        else $error("enables or flags not clear after reset");

    chk_enable_write: assert property (
        bus_req.wr && bus_req.addr == ADDR_INT
        |=> st_r.enable == $past(bus_req.wdata[INT_EN_LSB +: EVT_N]))
        else $error("enable write not stored");

    chk_jabber_set: assert property (
        chk_set[EVT_N-1] |=> st_r.flags[EVT_N-1] ##1 1'b1)
        else $error("jabber flag not set");

    chk_read_clears: assert property (
        s_read_int ##0 (chk_set == '0) |=> st_r.flags == '0)
        else $error("flags not cleared by read");

    chk_set_wins: assert property (
        s_read_int ##0 chk_set[0] |=> st_r.flags[0])
        else $error("event lost during clearing read");

    chk_link_loss: assert property (
        s_link_drop |=> st_r.flags[LINK_LOSS_BIT])
        else $error("link loss not flagged");

    chk_int_readback: assert property (
        s_read_int |=> bus_rdata == {$past(st_r.enable), $past(st_r.flags)}
        ##1 bus_rdata == '0 || $past(bus_req.rd))
        else $error("interrupt register read data wrong");

    chk_diag_reserved: assert property (
        s_read_diag |=> bus_rdata[15:12] == 4'h0 && bus_rdata[7:0] == 8'h00)
        else $error("reserved diagnostic bits not zero");

    chk_rx_pass: assert property (
        s_read_diag |=> bus_rdata[DIAG_PASS_BIT] ==
            ($past(st_r.st_s2.mode_100x) ? $past(st_r.st_s2.signal_valid)
                                         : $past(st_r.st_s2.manchester_seen)))
        else $error("receive pass bit mismatch");

    chk_lock_sticky: assert property (
        st_r.lock_sticky && !(bus_req.rd && bus_req.addr == ADDR_DIAG) |=> st_r.lock_sticky)
        else $error("lock bit dropped without read");

    chk_irq_pin: assert property (
        interrupt_output_pin == (chk_irq ~^ $past(interrupt_polarity_select)))
        else $error("interrupt pin level wrong");

    chk_pwr_reset: assert property (
        disable iff (1'b0) srst |=> pwr_ctrl.low_power && !pwr_ctrl.digital_loopback
        && pwr_ctrl.transformer_ratio_select == $past(st_r.strap_s2))
        else $error("power register reset value wrong");

    chk_strap_load: assert property (
        st_r.rst_d && !bus_req.wr
        |=> pwr_ctrl.transformer_ratio_select == $past(st_r.strap_s2))
        else $error("ratio strap not loaded after reset");

    chk_flag_hold: assert property (
        !(bus_req.rd && bus_req.addr == ADDR_INT)
        |=> (st_r.flags & $past(st_r.flags)) == $past(st_r.flags))
        else $error("event flag dropped without read");

    chk_event_flags: assert property (
        chk_set != '0 |=> (st_r.flags & $past(chk_set)) == $past(chk_set))
        else $error("event edge not flagged");

    chk_no_spurious: assert property (
        chk_set == '0 && !(bus_req.rd && bus_req.addr == ADDR_INT)
        |=> st_r.flags == $past(st_r.flags))
        else $error("flag changed without event or read");

    chk_ack_flag: assert property (
        chk_set[3] |=> st_r.flags[3])
        else $error("partner acknowledge flag not set");

    chk_fault_flag: assert property (
        chk_set[1] |=> st_r.flags[1])
        else $error("remote fault flag not set");

    chk_enable_hold: assert property (
        !(bus_req.wr && bus_req.addr == ADDR_INT) |=> $stable(st_r.enable))
        else $error("enables changed without write");

    chk_rdata_idle: assert property (
        !bus_req.rd |=> bus_rdata == '0)
        else $error("read data not zero outside a read");

    chk_diag_negotiated_full_duplex: assert property (
        s_read_diag |=> bus_rdata[DIAG_NEGOTIATED_FULL_DUPLEX_BIT] == $past(st_r.st_s2.full_duplex))
        else $error("duplex bit mismatch");

    chk_diag_speed: assert property (
        s_read_diag |=> bus_rdata[DIAG_SPEED_BIT] == $past(st_r.st_s2.speed_100))
        else $error("speed bit mismatch");

    chk_diag_manch: assert property (
        s_read_diag ##0 !st_r.st_s2.mode_100x
        |=> bus_rdata[DIAG_PASS_BIT] == $past(st_r.st_s2.manchester_seen))
        else $error("manchester pass bit mismatch");

    chk_lock_set: assert property (
        st_r.st_s2.pll_lock && !st_r.lock_d |=> st_r.lock_sticky)
        else $error("lock bit not set on lock");

    chk_lock_clear: assert property (
        s_read_diag ##0 !(st_r.st_s2.pll_lock && !st_r.lock_d) |=> !st_r.lock_sticky)
        else $error("lock bit not cleared by read");

    chk_lock_read: assert property (
        s_read_diag |=> bus_rdata[DIAG_LOCK_BIT] == $past(st_r.lock_sticky))
        else $error("lock bit read wrong");

    chk_pwr_write: assert property (
        bus_req.wr && bus_req.addr == ADDR_PWR
        |=> pwr_ctrl == $past(bus_req.wdata[PWR_FIELD_W-1:0]))
        else $error("power write not stored");

    chk_pwr_hold: assert property (
        !(bus_req.wr && bus_req.addr == ADDR_PWR) && !st_r.rst_d |=> $stable(pwr_ctrl))
        else $error("power bits changed without write");

    chk_pwr_readback: assert property (
        bus_req.rd && bus_req.addr == ADDR_PWR |=> bus_rdata == {1'b0, $past(pwr_ctrl)})
        else $error("power register read data wrong");

    chk_irq_clear: assert property (
        s_read_int ##0 (chk_set == '0) ##0 interrupt_polarity_select
        |=> !interrupt_output_pin)
        else $error("interrupt pin still active after read");

    chk_irq_raise: assert property (
        (chk_set & st_r.enable) != '0 && !bus_req.wr && interrupt_polarity_select
        |=> interrupt_output_pin)
        else $error("interrupt pin not raised by enabled event");

endmodule

`default_nettype wire

// ===== test/pidl_phy_model.sv
// Purpose: far-side event and status source for the register bank
// Assumes: levels held several clocks so the synchronisers see them
// Notes:   link_good idles high; fire toggles one line for 3 clocks
`timescale 1ns/1ps
`default_nettype none
module pidl_phy_model
    import pidl_pkg::*;
(
    input  wire logic                  clk_sys,
    output var pidl_pkg::pidl_event_t  phy_event,
    output var pidl_pkg::pidl_status_t phy_status
);
    initial begin
        phy_event  = pidl_event_t'(8'h04);
        phy_status = '0;
    end
    // restore afterwards so only one edge of interest is made
    task automatic fire(input int unsigned idx);
        logic [7:0] v;
        v = phy_event;
        v[idx] = ~v[idx];
        @(posedge clk_sys);
        phy_event <= v;
        repeat (3) @(posedge clk_sys);
        phy_event <= pidl_event_t'(8'h04);
    endtask
    task automatic set_status(input logic [5:0] s);
        @(posedge clk_sys);
        phy_status <= s;
    endtask
endmodule
`default_nettype wire

// ===== test/pidl_regs_test.sv
// Purpose: self-checking bench for the interrupt/diagnostic/power bank
// Assumes: one clock, bus master tasks change signals after an edge
// Notes:   reset held 2 edges; design retakes the strap after release
`timescale 1ns/1ps
`default_nettype none
module pidl_regs_test;
    import pidl_pkg::*;
    logic              clk_sys = 1'b0;
    logic              srst = 1'b1;
    pidl_bus_req_t     bus_req = '0;
    logic [DATA_W-1:0] bus_rdata;
    pidl_event_t       phy_event;
    pidl_status_t      phy_status;
    logic              ratio_strap = 1'b1;
    logic              interrupt_polarity_select = 1'b1;
    pidl_pwr_t         pwr_ctrl;
    logic              interrupt_output_pin;
    logic [15:0]       exp;
    int                n_fail = 0;
    int                total_checks = 0;
    always #5 clk_sys = ~clk_sys;
    pidl_phy_model pidl_phy_model_i (.clk_sys(clk_sys), .phy_event(phy_event),
        .phy_status(phy_status));
    pidl_regs pidl_regs_i (.clk_sys(clk_sys), .srst(srst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .phy_event(phy_event), .phy_status(phy_status),
        .ratio_strap(ratio_strap), .interrupt_polarity_select(interrupt_polarity_select),
        .pwr_ctrl(pwr_ctrl), .interrupt_output_pin(interrupt_output_pin));
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        total_checks++;
        if (got !== want) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, input logic [15:0] want);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1 chk(bus_rdata, want);
    endtask
    task automatic pin(input logic want);
        repeat (2) @(posedge clk_sys);
        #1 chk({15'h0000, interrupt_output_pin}, {15'h0000, want});
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        results();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        rd(ADDR_INT, 16'h0000);
        rd(ADDR_DIAG, 16'h0000);
        rd(ADDR_PWR, 16'h0060);
        rd(5'h10, 16'h0000);
        pin(1'b0);
        $display("test reset done");
        wr(ADDR_INT, 16'hFFFF);
        rd(ADDR_INT, 16'hFF00);
        for (int i = 0; i < 8; i++) begin
            pidl_phy_model_i.fire(i);
            repeat (3) @(posedge clk_sys);
            exp = 16'hFF00 | (16'h0001 << i);
            pin(1'b1);
            rd(ADDR_INT, exp);
            pin(1'b0);
            rd(ADDR_INT, 16'hFF00);
        end
        $display("test events done");
        wr(ADDR_INT, 16'h7F00);
        pidl_phy_model_i.fire(7);
        repeat (3) @(posedge clk_sys);
        pin(1'b0);
        @(posedge clk_sys) interrupt_polarity_select <= 1'b0;
        pin(1'b1);
        wr(ADDR_INT, 16'hFF00);
        pin(1'b0);
        rd(ADDR_INT, 16'hFF80);
        pin(1'b1);
        @(posedge clk_sys) interrupt_polarity_select <= 1'b1;
        $display("test mask done");
        pidl_phy_model_i.set_status(6'b111101);
        repeat (4) @(posedge clk_sys);
        rd(ADDR_DIAG, 16'h0F00);
        rd(ADDR_DIAG, 16'h0E00);
        pidl_phy_model_i.set_status(6'b000110);
        repeat (4) @(posedge clk_sys);
        rd(ADDR_DIAG, 16'h0200);
        pidl_phy_model_i.set_status(6'b001010);
        wr(ADDR_DIAG, 16'hFFFF);
        repeat (4) @(posedge clk_sys);
        rd(ADDR_DIAG, 16'h0000);
        $display("test diag done");
        // walking one catches swapped or stuck control bits
        for (int i = 0; i < 16; i++) begin
            exp = 16'h0001 << i;
            wr(ADDR_PWR, exp);
            exp[15] = 1'b0;
            rd(ADDR_PWR, exp);
            chk({1'b0, pwr_ctrl}, exp);
        end
        $display("test power done");
        results();
    end
endmodule
`default_nettype wire
